// [rtl/cgc_pkg.sv]
// Summary of operation
// - Four stored PLL2 divider profiles; index from the switching inputs picks one.
// - Index changes on switch inputs retarget PLL2 smoothly, never jumping the clock.
// - Profile changes always ramp the divider in bounded steps, no overshoot.
// - Single-ended source from bits 0100, 1000, 1110, 1101 as 32k, PLL3, PLL2, REF.
// - Differential one from 00, 10, 01 as PLL1, PLL2, REF.
// - Differential two from 00, 10, 01 as PLL1, PLL2, REF.
// - Differential outputs never carry 32k; single-ended never carries PLL1.
// - Switching disabled forces index 0; pin-one function 11 gives index {0,pin}.
// - Otherwise serial pins give the index, or the byte-30 field in register mode.
// - Byte 63 bits 3:2 choose the profile targeted by setting writes.
// - Writes to bytes 16 to 19 land in the selected profile slot.
// - Control pin serves power-down, output enable, sleep watch or reset output.
// - Sleep watch moves single-ended output to 32k while the end oscillator stops.
// - Pin function resets to output enable; code 10 selects sleep watch.
// - The single-ended output has a slow or fast slew setting.
// - Timer lasts 0.5, 1, 2 or 4 seconds by a two-bit field.
// - Expiry sets the timeout flag; writing timer enable 0 clears it.
// - Expiry with reset output enabled drives a 250 ms low pulse on the pin.
// - Expiry with switching on forces profile 0, then disables switching after reset.
// - Suspend turns all outputs off except the 32.768 kHz clock.
// - Output-enable function gates only the single-ended output.
package cgc_pkg;
   // ******************************
   // Register byte offsets
   // ******************************
   localparam logic [5:0] OFS_DIFF_REF  = 6'h00;
   localparam logic [5:0] OFS_PROF_B0   = 6'h10;
   localparam logic [5:0] OFS_PROF_B3   = 6'h13;
   localparam logic [5:0] OFS_SE_C     = 6'h1D;
   localparam logic [5:0] OFS_PIN_FUN   = 6'h1E;
   localparam logic [5:0] OFS_SE_B     = 6'h1F;
   localparam logic [5:0] OFS_SW_CTL    = 6'h20;
   localparam logic [5:0] OFS_DIFFERENTIAL_OUTPUT_ONE     = 6'h22;
   localparam logic [5:0] OFS_DIFFERENTIAL_OUTPUT_TWO     = 6'h23;
   localparam logic [5:0] OFS_SE_A     = 6'h24;
   localparam logic [5:0] OFS_TIMER     = 6'h28;
   localparam logic [5:0] OFS_PROF_SEL  = 6'h3F;
   // ******************************
   // Field positions
   // ******************************
   localparam int BIT_DIFF_REF   = 3;
   localparam int BIT_SE_C       = 3;
   localparam int BIT_SE_B       = 1;
   localparam int BIT_SE_A_HI    = 4;
   localparam int BIT_SE_A_LO    = 3;
   localparam int BIT_DIFF_PLL2  = 7;
   localparam int BIT_SW_EN      = 4;
   localparam int BIT_SCL_MODE   = 3;
   localparam int FUN_HI         = 6;
   localparam int FUN_LO         = 5;
   localparam int BIT_TMR_EN     = 0;
   localparam int BIT_TMR_SEL_LO = 1;
   localparam int BIT_TMR_SEL_HI = 2;
   localparam int BIT_RST_EN     = 3;
   localparam int BIT_TMR_FLAG   = 4;
   localparam int BIT_SLEW_FAST  = 5;
   localparam int PSEL_HI        = 3;
   localparam int PSEL_LO        = 2;
   // ******************************
   // Reset values and codes
   // ******************************
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [1:0] FUN_OE        = 2'h0;
   localparam logic [1:0] FUN_PD        = 2'h1;
   localparam logic [1:0] FUN_SLEEP     = 2'h2;
   localparam logic [1:0] FUN_SWITCH    = 2'h3;
   localparam logic [3:0] SE_CODE_32K   = 4'h4;
   localparam logic [3:0] SE_CODE_PLL3  = 4'h8;
   localparam logic [3:0] SE_CODE_PLL2  = 4'hE;
   localparam logic [3:0] SE_CODE_REF   = 4'hD;
   localparam logic [1:0] DF_CODE_PLL1  = 2'h0;
   localparam logic [1:0] DF_CODE_PLL2  = 2'h2;
   localparam logic [1:0] DF_CODE_REF   = 2'h1;
   typedef enum logic [2:0] {SRC_STOP, SRC_REF, SRC_32K, SRC_PLL1, SRC_PLL2, SRC_PLL3} cgc_src_t;
   // ******************************
   // Timing
   // ******************************
   localparam int unsigned CLK_HZ         = 40000000;
   localparam int unsigned TIMER_BASE_MS  = 500;
   localparam int unsigned RST_PULSE_MS   = 250;
   localparam int unsigned TIMER_BASE_CYC = CLK_HZ / 1000 * TIMER_BASE_MS;
   localparam int unsigned RST_PULSE_CYC  = CLK_HZ / 1000 * RST_PULSE_MS;
   localparam int unsigned WATCH_US       = 50;
   localparam int unsigned WATCH_CYC      = CLK_HZ / 1000000 * WATCH_US;
   localparam int unsigned STEP_NS        = 1600;
   localparam int unsigned STEP_CYC       = (STEP_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam logic [31:0] DIV_STEP       = 32'h0000_1000;
endpackage : cgc_pkg

// [rtl/cgc_clock_gen_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module cgc_clock_gen_ctrl #(
   parameter int unsigned TIMER_BASE_CYCLES = cgc_pkg::TIMER_BASE_CYC,
   parameter int unsigned RST_PULSE_CYCLES  = cgc_pkg::RST_PULSE_CYC
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [5:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_we,
   input  wire logic             reg_re,
   output var  logic [7:0]       reg_rdata,
   input  wire logic             control_pin_one_in,
   output var  logic             control_pin_one_out,
   output var  logic             control_pin_one_oe_n,
   input  wire logic             serial_clock_index_high,
   input  wire logic             serial_data_index_low,
   input  wire logic             suspend_mode,
   output var  cgc_pkg::cgc_src_t single_ended_src,
   output var  cgc_pkg::cgc_src_t diff_one_src,
   output var  cgc_pkg::cgc_src_t diff_two_src,
   output var  logic             single_ended_slew_fast,
   output var  logic             low_power_osc_only,
   output var  logic [1:0]       profile_index,
   output var  logic [31:0]      pll2_divider,
   output var  logic             overshoot_limiter_busy,
   output var  logic             timeout_flag
);
   import cgc_pkg::*;

   // ******************************
   // Register storage
   // ******************************
   logic [7:0]  diff_ref_reg;
   logic [7:0]  se_c_reg;
   logic [7:0]  pin_fun_reg;
   logic [7:0]  se_b_reg;
   logic [7:0]  sw_ctl_reg;
   logic [7:0]  differential_output_one_reg;
   logic [7:0]  differential_output_two_reg;
   logic [7:0]  se_a_reg;
   logic [7:0]  timer_reg;
   logic [7:0]  prof_sel_reg;
   logic [31:0] profile_mem [4];

   function automatic logic wr_hit(input logic [5:0] ofs);
      wr_hit = reg_we && (reg_addr == ofs);
   endfunction : wr_hit

   // Differential decode shared by both outputs
   function automatic cgc_src_t diff_decode(input logic [1:0] code);
      case (code)
         DF_CODE_PLL1: diff_decode = SRC_PLL1;
         DF_CODE_PLL2: diff_decode = SRC_PLL2;
         DF_CODE_REF:  diff_decode = SRC_REF;
         default:      diff_decode = SRC_STOP;
      endcase
   endfunction : diff_decode

   wire logic [1:0] prof_sel   = prof_sel_reg[PSEL_HI:PSEL_LO];
   wire logic [1:0] pin_fun    = pin_fun_reg[FUN_HI:FUN_LO];
   wire logic       sw_enable  = sw_ctl_reg[BIT_SW_EN];
   wire logic       scl_mode   = sw_ctl_reg[BIT_SCL_MODE];
   wire logic       tmr_en     = timer_reg[BIT_TMR_EN];
   wire logic [1:0] tmr_sel    = timer_reg[BIT_TMR_SEL_HI:BIT_TMR_SEL_LO];
   wire logic       rst_out_en = timer_reg[BIT_RST_EN];
   wire logic       prof_wr    = reg_we && (reg_addr >= OFS_PROF_B0) && (reg_addr <= OFS_PROF_B3);
   wire logic [1:0] prof_lane  = reg_addr[1:0];

   // ******************************
   // Timer and reset pulse
   // ******************************
   logic [27:0] tmr_cnt;
   logic [27:0] pulse_cnt;
   logic        pulse_active;
   logic        force_zero;
   logic        disable_pending;
   wire  logic [27:0] tmr_limit = 28'(TIMER_BASE_CYCLES) << tmr_sel;
   wire  logic        tmr_expire = tmr_en && !timeout_flag && (tmr_cnt == tmr_limit - 28'h1);
   wire  logic        flag_clear = reg_we && (reg_addr == OFS_TIMER) && !reg_wdata[BIT_TMR_EN];
   wire  logic        pulse_done = pulse_active && (pulse_cnt == 28'(RST_PULSE_CYCLES) - 28'h1);
   wire  logic        hw_sw_off  = disable_pending && (!pulse_active || pulse_done);
   wire  logic [27:0] next_tmr_cnt = (!tmr_en || timeout_flag) ? 28'h0 : tmr_cnt + 28'h1;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tmr_cnt <= 28'h0;
      end else begin
         tmr_cnt <= next_tmr_cnt;
      end
   end

   // sticky timeout flag
   // Expiry beats a clear in the same cycle, so no timeout is lost
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timeout_flag <= 1'b0;
      end else if (tmr_expire) begin
         timeout_flag <= 1'b1;
      end else if (flag_clear) begin
         timeout_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulse_active <= 1'b0;
         pulse_cnt    <= 28'h0;
      end else if (tmr_expire && rst_out_en) begin
         pulse_active <= 1'b1;
         pulse_cnt    <= 28'h0;
      end else if (pulse_done) begin
         pulse_active <= 1'b0;
      end else if (pulse_active) begin
         pulse_cnt <= pulse_cnt + 28'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         force_zero      <= 1'b0;
         disable_pending <= 1'b0;
      end else if (tmr_expire && sw_enable) begin
         force_zero      <= 1'b1;
         disable_pending <= 1'b1;
      end else if (hw_sw_off) begin
         force_zero      <= 1'b0;
         disable_pending <= 1'b0;
      end
   end

   // reset output drive on the pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         control_pin_one_out  <= 1'b1;
         control_pin_one_oe_n <= 1'b1;
      end else begin
         control_pin_one_out  <= !pulse_active;
         control_pin_one_oe_n <= !rst_out_en;
      end
   end

   // ******************************
   // Register writes
   // ******************************
   // pin function defaults to output enable
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         diff_ref_reg <= RST_BYTE;
         se_c_reg     <= RST_BYTE;
         pin_fun_reg  <= {RST_BYTE[7], FUN_OE, RST_BYTE[4:0]};
         se_b_reg     <= RST_BYTE;
         differential_output_one_reg    <= RST_BYTE;
         differential_output_two_reg    <= RST_BYTE;
         se_a_reg     <= RST_BYTE;
         prof_sel_reg <= RST_BYTE;
      end else begin
         if (wr_hit(OFS_DIFF_REF)) diff_ref_reg <= reg_wdata;
         if (wr_hit(OFS_SE_C))     se_c_reg     <= reg_wdata;
         if (wr_hit(OFS_PIN_FUN))  pin_fun_reg  <= reg_wdata;
         if (wr_hit(OFS_SE_B))     se_b_reg     <= reg_wdata;
         if (wr_hit(OFS_DIFFERENTIAL_OUTPUT_ONE))    differential_output_one_reg    <= reg_wdata;
         if (wr_hit(OFS_DIFFERENTIAL_OUTPUT_TWO))    differential_output_two_reg    <= reg_wdata;
         if (wr_hit(OFS_SE_A))     se_a_reg     <= reg_wdata;
         if (wr_hit(OFS_PROF_SEL)) prof_sel_reg <= reg_wdata;
      end
   end

   // switching turns off after the reset pulse
   // A software write in the same cycle wins, so software keeps the last word
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sw_ctl_reg <= RST_BYTE;
      end else if (wr_hit(OFS_SW_CTL)) begin
         sw_ctl_reg <= reg_wdata;
      end else if (hw_sw_off) begin
         sw_ctl_reg[BIT_SW_EN] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timer_reg <= RST_BYTE;
      end else if (wr_hit(OFS_TIMER)) begin
         timer_reg <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_slot
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               profile_mem[g] <= 32'h0;
            end else if (prof_wr && (prof_sel == 2'(g))) begin
               profile_mem[g][8*prof_lane +: 8] <= reg_wdata;
            end
         end
      end
   endgenerate

   // ******************************
   // Register reads
   // ******************************
   wire logic [31:0] sel_slot = profile_mem[prof_sel];
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      if (prof_wr || (reg_re && reg_addr >= OFS_PROF_B0 && reg_addr <= OFS_PROF_B3)) begin
         next_rdata = sel_slot[8*prof_lane +: 8];
      end
      case (reg_addr)
         OFS_DIFF_REF: next_rdata = diff_ref_reg;
         OFS_SE_C:     next_rdata = se_c_reg;
         OFS_PIN_FUN:  next_rdata = pin_fun_reg;
         OFS_SE_B:     next_rdata = se_b_reg;
         OFS_SW_CTL:   next_rdata = sw_ctl_reg;
         OFS_DIFFERENTIAL_OUTPUT_ONE:    next_rdata = differential_output_one_reg;
         OFS_DIFFERENTIAL_OUTPUT_TWO:    next_rdata = differential_output_two_reg;
         OFS_SE_A:     next_rdata = se_a_reg;
         OFS_TIMER:    next_rdata = {timer_reg[7:5], timeout_flag, timer_reg[3:0]};
         OFS_PROF_SEL: next_rdata = prof_sel_reg;
         default:      next_rdata = next_rdata;
      endcase
      if (!reg_re) begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ******************************
   // Profile index selection
   // ******************************
   logic [1:0] next_index;
   always_comb begin
      next_index = 2'h0;
      if (!sw_enable || force_zero) begin
         next_index = 2'h0;
      end else if (pin_fun == FUN_SWITCH) begin
         next_index = {1'b0, control_pin_one_in};
      end else if (!scl_mode) begin
         next_index = {serial_clock_index_high, serial_data_index_low};
      end else begin
         next_index = pin_fun_reg[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         profile_index <= 2'h0;
      end else begin
         profile_index <= next_index;
      end
   end

   // ******************************
   // Overshoot limiter ramp
   // ******************************
   // Each step is a small divider move, so the PLL stays locked and the clock is clean
   logic [7:0]  step_cnt;
   wire  logic [31:0] target_div = profile_mem[profile_index];
   wire  logic        step_tick  = (step_cnt == 8'(STEP_CYC - 1));
   wire  logic        go_up      = pll2_divider < target_div;
   wire  logic [31:0] gap        = go_up ? target_div - pll2_divider : pll2_divider - target_div;
   wire  logic [31:0] next_div   = (gap <= DIV_STEP) ? target_div :
                                   go_up ? pll2_divider + DIV_STEP : pll2_divider - DIV_STEP;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         step_cnt <= 8'h0;
      end else begin
         step_cnt <= step_tick ? 8'h0 : step_cnt + 8'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pll2_divider           <= 32'h0;
         overshoot_limiter_busy <= 1'b0;
      end else begin
         if (step_tick) pll2_divider <= next_div;
         overshoot_limiter_busy <= pll2_divider != target_div;
      end
   end

   // ******************************
   // Sleep watch
   // ******************************
   logic        pin_prev;
   logic [15:0] watch_cnt;
   logic        end_asleep;
   wire  logic  pin_edge = control_pin_one_in ^ pin_prev;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_prev   <= 1'b0;
         watch_cnt  <= 16'h0;
         end_asleep <= 1'b0;
      end else begin
         pin_prev <= control_pin_one_in;
         if (pin_edge || pin_fun != FUN_SLEEP) begin
            watch_cnt  <= 16'h0;
            end_asleep <= 1'b0;
         end else if (watch_cnt == 16'(WATCH_CYC - 1)) begin
            end_asleep <= 1'b1;
         end else begin
            watch_cnt <= watch_cnt + 16'h1;
         end
      end
   end

   // ******************************
   // Output source routing
   // ******************************
   wire logic [3:0] se_code = {se_a_reg[BIT_SE_A_HI], se_a_reg[BIT_SE_A_LO],
                               se_b_reg[BIT_SE_B], se_c_reg[BIT_SE_C]};
   wire logic       pd_active = (pin_fun == FUN_PD) && !control_pin_one_in;
   wire logic       se_gated  = (pin_fun == FUN_OE) && !control_pin_one_in;
   cgc_src_t se_dec;
   cgc_src_t next_se;
   cgc_src_t next_d1;
   cgc_src_t next_d2;

   always_comb begin
      case (se_code)
         SE_CODE_32K:  se_dec = SRC_32K;
         SE_CODE_PLL3: se_dec = SRC_PLL3;
         SE_CODE_PLL2: se_dec = SRC_PLL2;
         SE_CODE_REF:  se_dec = SRC_REF;
         default:      se_dec = SRC_STOP;
      endcase
   end

   // suspend keeps only the 32k clock
   always_comb begin
      next_se = se_dec;
      if (end_asleep && se_dec != SRC_STOP) next_se = SRC_32K;
      if (se_gated) next_se = SRC_STOP;
      if ((pd_active || suspend_mode) && next_se != SRC_32K) next_se = SRC_STOP;
      next_d1 = diff_decode({differential_output_one_reg[BIT_DIFF_PLL2], diff_ref_reg[BIT_DIFF_REF]});
      next_d2 = diff_decode({differential_output_two_reg[BIT_DIFF_PLL2], diff_ref_reg[BIT_DIFF_REF]});
      if (pd_active || suspend_mode) begin
         next_d1 = SRC_STOP;
         next_d2 = SRC_STOP;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         single_ended_src       <= SRC_STOP;
         diff_one_src           <= SRC_STOP;
         diff_two_src           <= SRC_STOP;
         single_ended_slew_fast <= 1'b0;
         low_power_osc_only     <= 1'b0;
      end else begin
         single_ended_src       <= next_se;
         diff_one_src           <= next_d1;
         diff_two_src           <= next_d2;
         single_ended_slew_fast <= timer_reg[BIT_SLEW_FAST];
         low_power_osc_only     <= suspend_mode;
      end
   end

   // ******************************
   // Assertions
   // ******************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   diff_no_32k_a: assert property (diff_one_src != SRC_32K && diff_two_src != SRC_32K && single_ended_src != SRC_PLL1)
      else $error("illegal output source");
   sw_off_zero_a: assert property (!sw_enable |=> profile_index == 2'h0)
      else $error("index not forced to zero");
   flag_holds_a: assert property (timeout_flag && !flag_clear |=> timeout_flag)
      else $error("timeout flag dropped");
   pulse_length_a: assert property (pulse_active |-> pulse_cnt < 28'(RST_PULSE_CYCLES))
      else $error("reset pulse too long");
   no_overshoot_a: assert property (pll2_divider <= target_div |=> $changed(target_div) || pll2_divider <= target_div)
      else $error("divider overshoot");
   step_bound_a: assert property ((pll2_divider - $past(pll2_divider) <= DIV_STEP) || ($past(pll2_divider) - pll2_divider <= DIV_STEP))
      else $error("divider jump");
   suspend_stop_a: assert property (suspend_mode |=> diff_one_src == SRC_STOP && diff_two_src == SRC_STOP)
      else $error("outputs alive in suspend");
   se_32k_map_a: assert property (se_code == SE_CODE_32K && !se_gated |=> single_ended_src == SRC_32K)
      else $error("single-ended 32k routing");
   diff_rsvd_a: assert property (differential_output_one_reg[BIT_DIFF_PLL2] && diff_ref_reg[BIT_DIFF_REF] |=> diff_one_src == SRC_STOP)
      else $error("reserved code not stopped");
   fallback_a: assert property (tmr_expire && sw_enable |=> ##1 profile_index == 2'h0)
      else $error("no fall back to profile zero");
endmodule : cgc_clock_gen_ctrl
`default_nettype wire

// [dv/cgc_board_model.sv]
`timescale 1ns/10ps
`default_nettype none
module cgc_board_model (
   input  wire logic       clk,
   input  wire logic       osc_on,
   input  wire logic       idle_level,
   input  wire logic [1:0] index_pins,
   output var  logic       pin_level,
   output var  logic       scl_level,
   output var  logic       sda_level
);
   logic [3:0] div_cnt = 4'h0;
   logic       osc     = 1'b0;
   always_ff @(posedge clk) begin
      div_cnt <= div_cnt + 4'h1;
      if (div_cnt == 4'hF) osc <= ~osc;
   end
   // Stopped oscillator parks at a level
   assign pin_level = osc_on ? osc : idle_level;
   assign scl_level = index_pins[1];
   assign sda_level = index_pins[0];
endmodule : cgc_board_model
`default_nettype wire

// [dv/clock_gen_ctrl_logic_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module clock_gen_ctrl_logic_bench;
   import cgc_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, susp = 1'b0;
   logic        osc_on = 1'b0, lvl = 1'b1, pin, p_out, oe_n, scl, sda, slew, lp, busy, flag;
   logic [5:0]  addr = 6'h00;
   logic [7:0]  wd = 8'h00, rdata, d;
   logic [1:0]  pidx = 2'h0, idx;
   logic [31:0] div;
   cgc_src_t    se, d1, d2;
   int          miscompares = 0, checks_done = 0, n;
   always #12.5 clk = ~clk;
   cgc_clock_gen_ctrl #(.TIMER_BASE_CYCLES(100), .RST_PULSE_CYCLES(20)) dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd), .reg_we(we), .reg_re(re),
      .reg_rdata(rdata), .control_pin_one_in(pin), .control_pin_one_out(p_out),
      .control_pin_one_oe_n(oe_n), .serial_clock_index_high(scl), .serial_data_index_low(sda),
      .suspend_mode(susp), .single_ended_src(se), .diff_one_src(d1), .diff_two_src(d2),
      .single_ended_slew_fast(slew), .low_power_osc_only(lp), .profile_index(idx),
      .pll2_divider(div), .overshoot_limiter_busy(busy), .timeout_flag(flag));
   cgc_board_model board (.clk(clk), .osc_on(osc_on), .idle_level(lvl), .index_pins(pidx),
      .pin_level(pin), .scl_level(scl), .sda_level(sda));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wd <= v;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd
   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic t_reset();
      settle(2);
      chk("se_src", SRC_STOP, se);
      chk("diff_one", SRC_PLL1, d1);
      chk("pin_out", 1, {p_out, oe_n} == 2'b11);
      rd(OFS_PIN_FUN);
      chk("pin_fun", 8'h00, d);
      rd(6'h3E);
      chk("unmapped", 8'h00, d);
   endtask : t_reset
   task automatic t_routes();
      logic [3:0] sc[5] = '{4'h4, 4'h8, 4'hE, 4'hD, 4'h0};
      cgc_src_t   se_e[5] = '{SRC_32K, SRC_PLL3, SRC_PLL2, SRC_REF, SRC_STOP};
      cgc_src_t   df_e[4] = '{SRC_PLL1, SRC_REF, SRC_PLL2, SRC_STOP};
      for (int i = 0; i < 5; i++) begin
         wr(OFS_SE_A, {3'h0, sc[i][3:2], 3'h0});
         wr(OFS_SE_B, {6'h00, sc[i][1], 1'b0});
         wr(OFS_SE_C, {4'h0, sc[i][0], 3'h0});
         settle(3);
         chk("se_src", se_e[i], se);
      end
      for (int i = 0; i < 4; i++) begin
         wr(OFS_DIFFERENTIAL_OUTPUT_ONE, {i[1], 7'h00});
         wr(OFS_DIFFERENTIAL_OUTPUT_TWO, {i[1], 7'h00});
         wr(OFS_DIFF_REF, {4'h0, i[0], 3'h0});
         settle(3);
         chk("diff_one", df_e[i], d1);
         chk("diff_two", df_e[i], d2);
      end
   endtask : t_routes
   task automatic wprof(input logic [1:0] s, input logic [31:0] v);
      wr(OFS_PROF_SEL, {4'h0, s, 2'h0});
      for (int i = 0; i < 4; i++) wr(OFS_PROF_B0 + 6'(i), v[8*i+:8]);
   endtask : wprof
   task automatic t_switch();
      wprof(2'h1, 32'h0000_4000);
      wprof(2'h2, 32'h0000_2000);
      pidx <= 2'h1;
      wr(OFS_SW_CTL, 8'h10);
      settle(3);
      chk("index", 2'h1, idx);
      chk("limiter busy", 1'b1, busy);
      for (n = 0; n < 1000 && (busy !== 1'b0 || div !== 32'h4000); n++) begin
         @(negedge clk);
         if (div > 32'h4000) chk("overshoot", 32'h4000, div);
      end
      chk("divider", 32'h0000_4000, div);
      wr(OFS_PIN_FUN, 8'h62);
      settle(3);
      chk("index", 2'h1, idx);
      @(posedge clk);
      lvl <= 1'b0;
      settle(3);
      chk("index", 2'h0, idx);
      wr(OFS_PIN_FUN, 8'h02);
      wr(OFS_SW_CTL, 8'h18);
      settle(3);
      chk("index", 2'h2, idx);
      wr(OFS_SW_CTL, 8'h00);
      settle(3);
      chk("index", 2'h0, idx);
      wr(OFS_SW_CTL, 8'h10);
      lvl <= 1'b1;
   endtask : t_switch
   task automatic t_expiry();
      wr(OFS_TIMER, 8'h09);
      for (n = 0; n < 200 && flag !== 1'b1; n++) @(negedge clk);
      chk("expiry", 1, n >= 98 && n <= 104);
      for (n = 0; n < 10 && p_out !== 1'b0; n++) @(negedge clk);
      for (n = 0; n < 50 && p_out === 1'b0; n++) @(negedge clk);
      chk("pulse", 20, n);
      chk("oe_n", 1'b0, oe_n);
      chk("index", 2'h0, idx);
      rd(OFS_SW_CTL);
      chk("switch en", 1'b0, d[BIT_SW_EN]);
      rd(OFS_TIMER);
      chk("flag", 1'b1, d[BIT_TMR_FLAG]);
      wr(OFS_TIMER, 8'h00);
      settle(3);
      chk("flag", 1'b0, flag);
      for (int s = 0; s < 4; s++) begin
         wr(OFS_TIMER, {5'h00, 2'(s), 1'b1});
         for (n = 0; n < 1000 && flag !== 1'b1; n++) @(negedge clk);
         chk("expiry", 1, n >= (100 << s) - 2 && n <= (100 << s) + 4);
         wr(OFS_TIMER, 8'h00);
      end
   endtask : t_expiry
   task automatic t_pin_modes();
      wr(OFS_PIN_FUN, 8'h40);
      wr(OFS_SE_A, 8'h10);
      wr(OFS_SE_C, 8'h00);
      wr(OFS_DIFFERENTIAL_OUTPUT_ONE, 8'h80);
      wr(OFS_DIFF_REF, 8'h00);
      osc_on <= 1'b1;
      settle(100);
      chk("se_src", SRC_PLL3, se);
      @(posedge clk) osc_on <= 1'b0;
      settle(2100);
      chk("se_src", SRC_32K, se);
      @(posedge clk) osc_on <= 1'b1;
      settle(40);
      chk("se_src", SRC_PLL3, se);
      @(posedge clk) osc_on <= 1'b0;
      lvl <= 1'b0;
      wr(OFS_PIN_FUN, 8'h00);
      settle(3);
      chk("se_src", SRC_STOP, se);
      chk("diff_one", SRC_PLL2, d1);
      wr(OFS_PIN_FUN, 8'h20);
      settle(3);
      chk("diff_one", SRC_STOP, d1);
      chk("se_src", SRC_STOP, se);
      @(posedge clk) lvl <= 1'b1;
      wr(OFS_TIMER, 8'h20);
      susp <= 1'b1;
      settle(3);
      chk("slew", 1'b1, slew);
      chk("low power", 1'b1, lp);
      chk("se_src", SRC_STOP, se);
   endtask : t_pin_modes
   task automatic complete_run();
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_routes();
      t_switch();
      t_expiry();
      t_pin_modes();
      complete_run();
   end
   initial begin
      #(25 * 40000);
      miscompares++;
      complete_run();
   end
endmodule : clock_gen_ctrl_logic_bench
`default_nettype wire
